// [logic/pcr_regs.vh]
// Register map, field positions, reset values and decode constants.
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// Offsets are register indexes; the byte address is four times each.
`define PCR_IDX_DIV 6'h19
`define PCR_IDX_OSC 6'h1a
`define PCR_IDX_REF 6'h1b
`define PCR_IDX_RSA 6'h1c
`define PCR_IDX_RSB 6'h1d
`define PCR_ADDR_DIV 8'h64
`define PCR_ADDR_OSC 8'h68
`define PCR_ADDR_REF 8'h6c
`define PCR_ADDR_RSA 8'h70
`define PCR_ADDR_RSB 8'h74
`define PCR_ADDR_STAT 8'h78

`define PCR_RST_DIV 16'h0440
`define PCR_RST_OSC 16'h0020
`define PCR_RST_REF 16'h0000
`define PCR_RST_RSV 16'h0000

`define PCR_M_HI 15
`define PCR_M_LO 8
`define PCR_N_HI 7
`define PCR_N_LO 4
`define PCR_BIAS_HI 3
`define PCR_BIAS_LO 2
`define PCR_VCO_HI 15
`define PCR_VCO_LO 10
`define PCR_BIAS_SLP 7
`define PCR_TSNS_SLP 6
`define PCR_LOOP_SLP 5
`define PCR_CLKR_SLP 4
`define PCR_EXT_REF 15
`define PCR_FUSE_SLP 11

`define PCR_M_MIN 8'h04
`define PCR_M_MAX 8'h7f

`endif

// [logic/pcr_div_decode.v]
// Decode of the loop divider fields into M and N ratios.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.vh"
module pcr_div_decode (
    // Fields
    input wire [7:0] m_field_i,
    input wire [3:0] n_field_i,
    // Ratios
    output wire [7:0] m_ratio_o,
    output wire m_valid_o,
    output wire [4:0] n_ratio_o
);
    wire [6:0] low7 = m_field_i[6:0];
    // Doubling keeps the ratio in eight bits, so 254 is the top value.
    assign m_ratio_o = m_field_i[7] ? {low7, 1'b0} : {1'b0, low7};
    // Invalid low codes 0 to 3 become 0 to 6 when doubled; same test.
    assign m_valid_o = ({1'b0, low7} >= `PCR_M_MIN);
    assign n_ratio_o = {1'b0, n_field_i} + 5'h01;
endmodule // pcr_div_decode
`default_nettype wire

// [logic/pcr_top.v]
// APB register bank for clock loop dividers, tuning and sleep controls.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.vh"
module pcr_top (
    // Clock and reset
    input wire CORE_CLK_I,
    input wire ARST_N_I,
    // APB slave
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [3:0] PSTRB_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    // Loop configuration
    output reg [7:0] LOOP_M_RATIO_O,
    output reg LOOP_M_VALID_O,
    output reg [4:0] LOOP_N_RATIO_O,
    output reg [1:0] OSC_BIAS_TUNE_O,
    output reg [5:0] OSC_COARSE_TUNE_O,
    // Sleep and reference controls
    output reg BIAS_AMP_SLEEP_O,
    output reg TEMP_SENSE_OFF_O,
    output reg LOOP_SLEEP_O,
    output reg CLK_RECV_SLEEP_O,
    output reg OUTPUT_STROBE_INPUT_SLEEP_O,
    output reg EXT_REF_SEL_O,
    output reg FUSE_SLEEP_O
);
    reg [15:0] div_reg;
    reg [15:0] osc_reg;
    reg [15:0] ref_reg;
    reg [15:0] rsa_reg;
    reg [15:0] rsb_reg;
    reg [15:0] div_next;
    reg [15:0] osc_next;
    reg [15:0] ref_next;
    reg [15:0] rsa_next;
    reg [15:0] rsb_next;
    reg [31:0] rdata_next;
    reg err_next;
    wire [7:0] m_ratio;
    wire m_valid;
    wire [4:0] n_ratio;
    wire access = PSEL_I & PENABLE_I;
    wire setup = PSEL_I & ~PENABLE_I;
    wire wr = access & PWRITE_I & PREADY_O;
    wire [15:0] wmask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
    wire aligned = (PADDR_I[1:0] == 2'b00);

    // Ready is a flop set by the setup cycle, so the first access cycle
    // completes; read data is loaded at that same edge and stands with it.

    function [15:0] merge;
        input [15:0] old;
        input [15:0] wdat;
        input [15:0] mask;
        begin
            merge = (old & ~mask) | (wdat & mask);
        end
    endfunction

    pcr_div_decode u_dec (
        .m_field_i(div_reg[`PCR_M_HI:`PCR_M_LO]),
        .n_field_i(div_reg[`PCR_N_HI:`PCR_N_LO]),
        .m_ratio_o(m_ratio),
        .m_valid_o(m_valid),
        .n_ratio_o(n_ratio)
    );

    always @* begin
        div_next = div_reg;
        osc_next = osc_reg;
        ref_next = ref_reg;
        rsa_next = rsa_reg;
        rsb_next = rsb_reg;
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        if (PSEL_I) begin
            if (!aligned) begin
                err_next = 1'b1;
            end else begin
                case (PADDR_I)
                    `PCR_ADDR_DIV: begin
                        rdata_next = {16'h0000, div_reg};
                        if (wr) begin
                            div_next = merge(div_reg, PWDATA_I[15:0], wmask);
                        end
                    end
                    `PCR_ADDR_OSC: begin
                        rdata_next = {16'h0000, osc_reg};
                        if (wr) begin
                            osc_next = merge(osc_reg, PWDATA_I[15:0], wmask);
                        end
                    end
                    `PCR_ADDR_REF: begin
                        rdata_next = {16'h0000, ref_reg};
                        if (wr) begin
                            ref_next = merge(ref_reg, PWDATA_I[15:0], wmask);
                        end
                    end
                    `PCR_ADDR_RSA: begin
                        // Factory word: stored so software sees what it wrote.
                        rdata_next = {16'h0000, rsa_reg};
                        if (wr) begin
                            rsa_next = merge(rsa_reg, PWDATA_I[15:0], wmask);
                        end
                    end
                    `PCR_ADDR_RSB: begin
                        rdata_next = {16'h0000, rsb_reg};
                        if (wr) begin
                            rsb_next = merge(rsb_reg, PWDATA_I[15:0], wmask);
                        end
                    end
                    `PCR_ADDR_STAT: begin
                        // Read-only view of the decoded loop ratios.
                        rdata_next = {16'h0000, m_valid, 2'b00, n_ratio,
                                      m_ratio};
                        if (PWRITE_I) begin
                            err_next = 1'b1;
                        end
                    end
                    default: begin
                        err_next = 1'b1;
                    end
                endcase
            end
        end
    end

    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            div_reg <= `PCR_RST_DIV;
            osc_reg <= `PCR_RST_OSC;
            ref_reg <= `PCR_RST_REF;
            rsa_reg <= `PCR_RST_RSV;
            rsb_reg <= `PCR_RST_RSV;
            PRDATA_O <= 32'h00000000;
            PSLVERR_O <= 1'b0;
            PREADY_O <= 1'b0;
        end else begin
            div_reg <= div_next;
            osc_reg <= osc_next;
            ref_reg <= ref_next;
            rsa_reg <= rsa_next;
            rsb_reg <= rsb_next;
            PRDATA_O <= rdata_next;
            PSLVERR_O <= err_next;
            PREADY_O <= setup;
        end
    end

    // Outputs follow the stored fields one cycle later so they come from flops.
    always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            LOOP_M_RATIO_O <= 8'h04;
            LOOP_M_VALID_O <= 1'b1;
            LOOP_N_RATIO_O <= 5'h05;
            OSC_BIAS_TUNE_O <= 2'h0;
            OSC_COARSE_TUNE_O <= 6'h00;
            BIAS_AMP_SLEEP_O <= 1'b0;
            TEMP_SENSE_OFF_O <= 1'b0;
            LOOP_SLEEP_O <= 1'b1;
            CLK_RECV_SLEEP_O <= 1'b0;
            OUTPUT_STROBE_INPUT_SLEEP_O <= 1'b0;
            EXT_REF_SEL_O <= 1'b0;
            FUSE_SLEEP_O <= 1'b0;
        end else begin
            LOOP_M_RATIO_O <= m_ratio;
            LOOP_M_VALID_O <= m_valid;
            LOOP_N_RATIO_O <= n_ratio;
            // Passed through as written; 01 is up to software.
            OSC_BIAS_TUNE_O <= div_reg[`PCR_BIAS_HI:`PCR_BIAS_LO];
            OSC_COARSE_TUNE_O <= osc_reg[`PCR_VCO_HI:`PCR_VCO_LO];
            BIAS_AMP_SLEEP_O <= osc_reg[`PCR_BIAS_SLP];
            TEMP_SENSE_OFF_O <= osc_reg[`PCR_TSNS_SLP];
            LOOP_SLEEP_O <= osc_reg[`PCR_LOOP_SLP];
            CLK_RECV_SLEEP_O <= osc_reg[`PCR_CLKR_SLP];
            OUTPUT_STROBE_INPUT_SLEEP_O <= osc_reg[`PCR_CLKR_SLP];
            EXT_REF_SEL_O <= ref_reg[`PCR_EXT_REF];
            // Reset value 0 leaves fuses awake until software sets it.
            FUSE_SLEEP_O <= ref_reg[`PCR_FUSE_SLP];
        end
    end
endmodule // pcr_top
`default_nettype wire

// [sim/pcr_monitor.sv]
// Assertion checker for the loop divider and sleep register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.vh"
module pcr_monitor (
    // Clock, reset and bus
    input wire logic CORE_CLK_I, ARST_N_I, PSEL_I, PENABLE_I, PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic PREADY_O,
    // Watched outputs
    input wire logic LOOP_M_VALID_O, BIAS_AMP_SLEEP_O, TEMP_SENSE_OFF_O,
    input wire logic LOOP_SLEEP_O, CLK_RECV_SLEEP_O, EXT_REF_SEL_O,
    input wire logic OUTPUT_STROBE_INPUT_SLEEP_O, FUSE_SLEEP_O,
    input wire logic [7:0] LOOP_M_RATIO_O,
    input wire logic [4:0] LOOP_N_RATIO_O,
    input wire logic [5:0] OSC_COARSE_TUNE_O
);
    logic [15:0] div_w, osc_w, ref_w;
    wire wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I &&
        PSTRB_I[1:0] == 2'b11;
    wire wr_div = wr && PADDR_I == `PCR_ADDR_DIV;
    wire wr_osc = wr && PADDR_I == `PCR_ADDR_OSC;
    wire wr_ref = wr && PADDR_I == `PCR_ADDR_REF;
    // Outputs lag the store by an edge, so each write check allows one or two.
    always_ff @(posedge CORE_CLK_I) begin
        if (wr_div) div_w <= PWDATA_I[15:0];
        if (wr_osc) osc_w <= PWDATA_I[15:0];
        if (wr_ref) ref_w <= PWDATA_I[15:0];
    end
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence s_wdiv; wr_div; endsequence
    sequence s_wosc; wr_osc; endsequence
    m_low_range_a: assert property (s_wdiv and !PWDATA_I[15] |-> ##[1:2]
        LOOP_M_RATIO_O == {1'b0, div_w[14:8]}
        && LOOP_M_VALID_O == (div_w[14:8] >= 7'd4)) else $error("m low");
    m_double_a: assert property (s_wdiv and PWDATA_I[15] |-> ##[1:2]
        LOOP_M_RATIO_O == {div_w[14:8], 1'b0}) else $error("m double");
    n_ratio_a: assert property (s_wdiv |-> ##[1:2]
        LOOP_N_RATIO_O == {1'b0, div_w[7:4]} + 5'd1) else $error("n ratio");
    coarse_tune_a: assert property (s_wosc |-> ##[1:2]
        OSC_COARSE_TUNE_O == osc_w[15:10]) else $error("coarse tune");
    sleep_bits_a: assert property (s_wosc |-> ##[1:2]
        {BIAS_AMP_SLEEP_O, TEMP_SENSE_OFF_O, LOOP_SLEEP_O} == osc_w[7:5])
        else $error("sleep bits");
    clk_recv_a: assert property (s_wosc |-> ##[1:2]
        CLK_RECV_SLEEP_O == osc_w[4]) else $error("receiver sleep");
    strobe_follow_a: assert property (
        OUTPUT_STROBE_INPUT_SLEEP_O == CLK_RECV_SLEEP_O) else $error("strobe");
    ref_select_a: assert property (wr_ref |-> ##[1:2]
        {EXT_REF_SEL_O, FUSE_SLEEP_O} == {ref_w[15], ref_w[11]})
        else $error("reference");
    reset_vals_a: assert property ($rose(ARST_N_I) |-> LOOP_SLEEP_O
        && LOOP_M_RATIO_O == 8'h04 && LOOP_N_RATIO_O == 5'h05) else $error("reset");
endmodule // pcr_monitor
bind pcr_top pcr_monitor mon (.*);
`default_nettype wire

// [sim/pcr_top_test.sv]
// Self-checking bench for the loop divider and sleep register bank.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.vh"
module pcr_top_test;
    typedef struct packed { logic [7:0] a; logic [31:0] d; } pcr_row_t;
    logic CORE_CLK_I = 0, ARST_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
    logic [7:0] PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
    logic [3:0] PSTRB_I = 4'hf;
    logic PREADY_O, PSLVERR_O, LOOP_M_VALID_O, BIAS_AMP_SLEEP_O, err;
    logic TEMP_SENSE_OFF_O, LOOP_SLEEP_O, CLK_RECV_SLEEP_O, FUSE_SLEEP_O;
    logic OUTPUT_STROBE_INPUT_SLEEP_O, EXT_REF_SEL_O;
    logic [7:0] LOOP_M_RATIO_O;
    logic [4:0] LOOP_N_RATIO_O;
    logic [1:0] OSC_BIAS_TUNE_O;
    logic [5:0] OSC_COARSE_TUNE_O;
    logic [15:0] sh [5];
    int failures = 0, samples_checked = 0;
    // Divider rows keep bias at 01 and bits 1:0 at zero; one row also sets bits 31:16 of the word.
    pcr_row_t rows [12] = '{'{8'h64, 32'h0304}, '{8'h64, 32'hdead_04f4},
        '{8'h64, 32'h7f14}, '{8'h64, 32'h8404}, '{8'h64, 32'hff04},
        '{8'h64, 32'h8304}, '{8'h68, 32'hfc80}, '{8'h68, 32'h0040},
        '{8'h68, 32'h0020}, '{8'h68, 32'h0010}, '{8'h6c, 32'h8000},
        '{8'h6c, 32'h0800}};
    wire [31:0] seen = {3'b0, LOOP_M_RATIO_O, LOOP_M_VALID_O, LOOP_N_RATIO_O,
        OSC_BIAS_TUNE_O, OSC_COARSE_TUNE_O, BIAS_AMP_SLEEP_O, TEMP_SENSE_OFF_O,
        LOOP_SLEEP_O, CLK_RECV_SLEEP_O, OUTPUT_STROBE_INPUT_SLEEP_O,
        EXT_REF_SEL_O, FUSE_SLEEP_O};
    pcr_top dut (.*);
    initial forever #2.5 CORE_CLK_I = ~CORE_CLK_I;
    function automatic logic [31:0] outs(input logic [15:0] v, o, r);
        logic [7:0] m;
        m = v[15] ? {v[14:8], 1'b0} : {1'b0, v[14:8]};
        return {3'b0, m, v[14:8] >= 7'd4, {1'b0, v[7:4]} + 5'd1, v[3:2],
            o[15:10], o[7:4], o[4], r[15], r[11]};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize;
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // This slave never stretches the access phase; the wait is bounded at 20 cycles anyway.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge CORE_CLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CORE_CLK_I) PENABLE_I <= 1'b1;
        do @(posedge CORE_CLK_I) n++;
        while (PREADY_O !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            summarize();
        end
        rd = PRDATA_O;
        err = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask
    task automatic reset_check;
        ARST_N_I <= 1'b0;
        repeat (3) @(posedge CORE_CLK_I);
        ARST_N_I <= 1'b1;
        sh = '{`PCR_RST_DIV, `PCR_RST_OSC, `PCR_RST_REF, 16'h0, 16'h0};
        chk(seen, outs(sh[0], sh[1], sh[2]));
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'h64 + 8'(4 * i), 32'h0);
            chk(rd, {16'h0, sh[i]});
        end
        apb(1'b0, `PCR_ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_8504);
    endtask
    initial begin
        reset_check();
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            sh[(rows[i].a - 8'h64) >> 2] = rows[i].d[15:0];
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, {16'h0, rows[i].d[15:0]});
            chk(seen, outs(sh[0], sh[1], sh[2]));
        end
        apb(1'b1, 8'h65, 32'hffff);
        chk(err, 1'b1);
        apb(1'b1, `PCR_ADDR_STAT, 32'hffff);
        chk(err, 1'b1);
        apb(1'b0, 8'h7c, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        PSTRB_I <= 4'h1;
        apb(1'b1, `PCR_ADDR_DIV, 32'h0000_ff14);
        PSTRB_I <= 4'hf;
        sh[0][7:0] = 8'h14;
        apb(1'b0, `PCR_ADDR_DIV, 32'h0);
        chk(rd, {16'h0, sh[0]});
        reset_check();
        summarize();
    end
endmodule // pcr_top_test
`default_nettype wire
